// [swsr_defines.svh]
// Timing, width and reset constants of the single-wire sensor link
`ifndef SWSR_DEFINES_SVH
`define SWSR_DEFINES_SVH
`define SWSR_CLK_MHZ 10
`define SWSR_T_START_US 800
`define SWSR_T_GO_US 30
`define SWSR_T_ACK_US 80
`define SWSR_T_RDY_US 80
`define SWSR_T_LOW_US 50
`define SWSR_T_H0_US 26
`define SWSR_T_H1_US 70
`define SWSR_T_END_US 50
`define SWSR_BITS 40
`define SWSR_CNT_W 14
`define SWSR_SAMP_W 32
`define SWSR_HUM_RST 16'h0000
`define SWSR_TEMP_RST 16'h0000
`endif

// [swsr_pkg.sv]
// Types of the single-wire sensor link
package swsr_pkg;
  typedef enum logic [3:0] {
    SWSR_SLEEP, SWSR_ARMED, SWSR_GO, SWSR_ACK_LOW, SWSR_ACK_HIGH,
    SWSR_BIT_LOW, SWSR_BIT_HIGH, SWSR_END_LOW, SWSR_MEASURE
  } swsr_state_t;

  typedef struct packed {
    swsr_state_t state;
    logic [13:0] cnt;
    logic [5:0] bitn;
    logic [39:0] shift;
    logic [15:0] hum;
    logic [15:0] temp;
    logic [2:0] sync;
    logic line;
    logic sda_out;
    logic sda_oe;
    logic meas_req;
    logic frame_done;
    logic busy;
  } swsr_core_t;

  typedef struct packed {
    logic [1:0][31:0] mem;
    logic wr_idx;
    logic rd_idx;
    logic [1:0] count;
    logic in_ready;
  } swsr_buf_t;
endpackage

// [swsr_samp_if.sv]
// Sample stream between the two-entry buffer and the link engine
interface swsr_samp_if;
  logic valid;
  logic ready;
  logic [31:0] data;
  modport src(output valid, output data, input ready);
  modport snk(input valid, input data, output ready);
endinterface

// [swsr_buf.sv]
// Two-entry sample buffer with valid and ready on both sides
`include "swsr_defines.svh"
module swsr_buf
  import swsr_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic in_valid,
  input wire logic [31:0] in_data,
  output logic in_ready,
  swsr_samp_if.src out
);
  swsr_buf_t q_reg;
  swsr_buf_t q_next;
  logic push;
  logic pop;

  assign push = in_valid && q_reg.in_ready;
  assign pop = out.ready && (q_reg.count != 2'h0);
  assign out.valid = (q_reg.count != 2'h0);
  assign out.data = q_reg.mem[q_reg.rd_idx];
  assign in_ready = q_reg.in_ready;

  always_comb begin
    q_next = q_reg;
    if (push) begin
      q_next.mem[q_reg.wr_idx] = in_data;
      q_next.wr_idx = ~q_reg.wr_idx;
    end
    if (pop) begin
      q_next.rd_idx = ~q_reg.rd_idx;
    end
    q_next.count = q_reg.count + {1'b0, push} - {1'b0, pop};
    // Ready is registered so a stall reaches the source without a combinational path
    q_next.in_ready = (q_next.count != 2'h2);
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q_reg <= '0;
      q_reg.in_ready <= 1'b1;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end
endmodule

// [swsr_sensor.sv]
// Device end of the single-wire temperature and humidity read link
`include "swsr_defines.svh"
module swsr_sensor
  import swsr_pkg::*;
#(
  parameter int START_CYC = `SWSR_T_START_US * `SWSR_CLK_MHZ
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clk_en,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic samp_valid,
  input wire logic [31:0] samp_data,
  output logic samp_ready,
  output logic meas_req,
  output logic frame_done,
  output logic busy
);
  localparam logic [13:0] GO_CYC = 14'(`SWSR_T_GO_US * `SWSR_CLK_MHZ);
  localparam logic [13:0] ACK_CYC = 14'(`SWSR_T_ACK_US * `SWSR_CLK_MHZ);
  localparam logic [13:0] RDY_CYC = 14'(`SWSR_T_RDY_US * `SWSR_CLK_MHZ);
  localparam logic [13:0] LOW_CYC = 14'(`SWSR_T_LOW_US * `SWSR_CLK_MHZ);
  localparam logic [13:0] H0_CYC = 14'(`SWSR_T_H0_US * `SWSR_CLK_MHZ);
  localparam logic [13:0] H1_CYC = 14'(`SWSR_T_H1_US * `SWSR_CLK_MHZ);
  localparam logic [13:0] END_CYC = 14'(`SWSR_T_END_US * `SWSR_CLK_MHZ);
  localparam logic [13:0] START_LAST = 14'(START_CYC - 1);
  localparam logic [5:0] LAST_BIT = 6'(`SWSR_BITS - 1);

  swsr_core_t q_reg;
  swsr_core_t q_next;
  swsr_samp_if samp ();

  swsr_buf u_buf (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clk_en(clk_en),
    .in_valid(samp_valid),
    .in_data(samp_data),
    .in_ready(samp_ready),
    .out(samp)
  );

  // Sample taken only once the frame is over, so each read returns the older value
  assign samp.ready = (q_reg.state == SWSR_MEASURE);

  function automatic logic done(input logic [13:0] cnt, input logic [13:0] len);
    done = (cnt == len - 14'h0001);
  endfunction

  function automatic logic [7:0] chk(input logic [15:0] h, input logic [15:0] t);
    chk = h[15:8] + h[7:0] + t[15:8] + t[7:0];
  endfunction

  // Two's complement in, sign plus magnitude on the wire
  function automatic logic [15:0] to_sm(input logic [15:0] t);
    logic [15:0] mag;
    mag = t[15] ? (~t + 16'h0001) : t;
    to_sm = {t[15], mag[14:0]};
  endfunction

  // One table of phase lengths, so every timed state ends the same way
  function automatic logic [13:0] phase_len(input swsr_state_t st, input logic one);
    unique case (st)
      SWSR_GO: phase_len = GO_CYC;
      SWSR_ACK_LOW: phase_len = ACK_CYC;
      SWSR_ACK_HIGH: phase_len = RDY_CYC;
      SWSR_BIT_LOW: phase_len = LOW_CYC;
      SWSR_BIT_HIGH: phase_len = one ? H1_CYC : H0_CYC;
      SWSR_END_LOW: phase_len = END_CYC;
      default: phase_len = 14'h0000;
    endcase
  endfunction

  logic phase_end;
  assign phase_end = done(q_reg.cnt, phase_len(q_reg.state, q_reg.shift[39]));

  always_comb begin
    q_next = q_reg;
    q_next.meas_req = 1'b0;
    q_next.frame_done = 1'b0;
    q_next.cnt = q_reg.cnt + 14'h0001;
    q_next.sync = {q_reg.sync[1:0], sda_in};
    if (q_reg.sync[2] == q_reg.sync[1]) begin
      q_next.line = q_reg.sync[2];
    end
    unique case (q_reg.state)
      SWSR_SLEEP: begin
        q_next.sda_oe = 1'b0;
        q_next.busy = 1'b0;
        // Any high seen on two samples in a row restarts the count, so a glitch never arms the link
        if (q_reg.line) begin
          q_next.cnt = '0;
        end else if (q_reg.cnt >= START_LAST) begin
          q_next.cnt = q_reg.cnt;
          q_next.state = SWSR_ARMED;
          q_next.busy = 1'b1;
        end
      end

      SWSR_ARMED: begin
        // Count held at zero so the turnaround is timed from the release
        q_next.cnt = '0;
        if (q_reg.line) begin
          q_next.state = SWSR_GO;
        end
      end

      SWSR_GO: begin
        // Short turnaround so the host pin has really switched to input
        if (phase_end) begin
          q_next.cnt = '0;
          q_next.sda_oe = 1'b1;
          q_next.shift = {q_reg.hum, q_reg.temp, chk(q_reg.hum, q_reg.temp)};
          q_next.state = SWSR_ACK_LOW;
        end
      end

      SWSR_ACK_LOW: begin
        if (phase_end) begin
          q_next.cnt = '0;
          q_next.sda_oe = 1'b0;
          q_next.state = SWSR_ACK_HIGH;
        end
      end

      SWSR_ACK_HIGH: begin
        if (phase_end) begin
          q_next.cnt = '0;
          q_next.bitn = '0;
          q_next.sda_oe = 1'b1;
          q_next.state = SWSR_BIT_LOW;
        end
      end

      SWSR_BIT_LOW: begin
        if (phase_end) begin
          q_next.cnt = '0;
          q_next.sda_oe = 1'b0;
          q_next.state = SWSR_BIT_HIGH;
        end
      end

      SWSR_BIT_HIGH: begin
        if (phase_end) begin
          q_next.cnt = '0;
          q_next.sda_oe = 1'b1;
          // Shift only after the high phase, so shift[39] stays the bit in flight
          q_next.shift = {q_reg.shift[38:0], 1'b0};
          q_next.bitn = q_reg.bitn + 6'h01;
          q_next.state = (q_reg.bitn == LAST_BIT) ? SWSR_END_LOW : SWSR_BIT_LOW;
        end
      end

      SWSR_END_LOW: begin
        if (phase_end) begin
          q_next.cnt = '0;
          q_next.sda_oe = 1'b0;
          q_next.meas_req = 1'b1;
          q_next.state = SWSR_MEASURE;
        end
      end

      SWSR_MEASURE: begin
        // Never waits: with no sample queued the old values are kept
        q_next.cnt = '0;
        if (samp.valid) begin
          q_next.hum = samp.data[31:16];
          q_next.temp = to_sm(samp.data[15:0]);
        end
        q_next.frame_done = 1'b1;
        q_next.busy = 1'b0;
        q_next.state = SWSR_SLEEP;
      end

      default: begin
        // Unused state codes fall back to sleep with the pin released
        q_next.state = SWSR_SLEEP;
        q_next.sda_oe = 1'b0;
        q_next.busy = 1'b0;
        q_next.cnt = '0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      q_reg <= '0;
      q_reg.state <= SWSR_SLEEP;
      q_reg.hum <= `SWSR_HUM_RST;
      q_reg.temp <= `SWSR_TEMP_RST;
      // Sync flops start at the pulled-up idle level, so no false start follows reset
      q_reg.sync <= 3'h7;
      q_reg.line <= 1'b1;
    end else if (clk_en) begin
      q_reg <= q_next;
    end
  end

  assign sda_out = q_reg.sda_out;
  assign sda_oe = q_reg.sda_oe;
  assign meas_req = q_reg.meas_req;
  assign frame_done = q_reg.frame_done;
  assign busy = q_reg.busy;
endmodule

// [swsr_chk_assertions.sv]
// Checker of the sensor end of the single-wire link
module swsr_chk #(
  parameter int START_CYC = 8000
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic meas_req,
  input wire logic frame_done,
  input wire logic busy
);
  logic oe_d_reg;
  logic [11:0] run_reg;
  logic [5:0] rise_reg;
  logic [15:0] low_reg;
  // Phase length is judged at the change, so run_reg holds the whole phase
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      oe_d_reg <= 1'b0;
      run_reg <= 12'h000;
      rise_reg <= 6'h00;
      low_reg <= 16'h0000;
    end else begin
      oe_d_reg <= sda_oe;
      run_reg <= (sda_oe != oe_d_reg) ? 12'h001 : run_reg + 12'h001;
      rise_reg <= !busy ? 6'h00 : rise_reg + 6'(sda_oe && !oe_d_reg);
      low_reg <= sda_in ? 16'h0000 : low_reg + 16'h0001;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  a_drive_low: assert property (sda_oe |-> !sda_out) else $error("driven high");
  a_low_len: assert property (oe_d_reg && !sda_oe |->
    run_reg == (rise_reg == 6'h01 ? 12'h320 : 12'h1f4)) else $error("low length");
  a_ready_len: assert property (!oe_d_reg && sda_oe && rise_reg == 6'h01 |->
    run_reg == 12'h320) else $error("ready length");
  a_bit_high: assert property (!oe_d_reg && sda_oe && rise_reg > 6'h01 |->
    run_reg == 12'h104 || run_reg == 12'h2bc) else $error("bit high");
  a_forty_bits: assert property (meas_req |-> rise_reg == 6'h2a && run_reg == 12'h1f4
    && oe_d_reg && !sda_oe) else $error("frame end");
  a_req_done: assert property (meas_req |-> ##[1:2] frame_done) else $error("no done");
  a_done_sleep: assert property (frame_done |-> !busy && !sda_oe) else $error("awake");
  a_sleep_quiet: assert property (!busy |-> !sda_oe) else $error("sleep drive");
  a_start_len: assert property ($rose(busy) |-> low_reg >= START_CYC)
    else $error("short start");
endmodule
bind swsr_sensor swsr_chk #(.START_CYC(START_CYC)) u_chk (.sys_clk, .rstn, .sda_in,
  .sda_out, .sda_oe, .meas_req, .frame_done, .busy);

// [swsr_host_model.sv]
// Host model: start pulse, release, bit decode by high length
module swsr_host_model (
  input wire logic sys_clk,
  input wire logic line,
  output logic host_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  initial host_oe = 1'b0;
  task automatic pulse(input int low_cyc);
    host_oe <= 1'b1;
    repeat (low_cyc) @(posedge sys_clk);
    host_oe <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Bounded wait, so a silent sensor cannot hang the host
  task automatic wait_lvl(input logic lvl, input int lim, output int n, inout logic ok);
    n = 0;
    while (line !== lvl && n < lim) begin
      @(posedge sys_clk);
      n++;
    end
    if (n >= lim) ok = 1'b0;
  endtask
  task automatic read(input int low_cyc, output logic [39:0] bits, output logic ok);
    int n;
    ok = 1'b1;
    pulse(low_cyc);
    wait_lvl(1'b0, 600, n, ok);
    wait_lvl(1'b1, 900, n, ok);
    wait_lvl(1'b0, 900, n, ok);
    for (int i = 39; i >= 0; i--) begin
      wait_lvl(1'b1, 600, n, ok);
      wait_lvl(1'b0, 900, n, ok);
      bits[i] = n > 480;
    end
    wait_lvl(1'b1, 600, n, ok);
  endtask
endmodule

// [test_single_wire_sensor_read.sv]
// Testbench of the sensor end of the single-wire link
module test_single_wire_sensor_read;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] SA = 32'h0292_ff9b;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic clk_en = 1'b1;
  logic samp_valid = 1'b0;
  logic [31:0] samp_data = 32'h0000_0000;
  logic sda_out, sda_oe, samp_ready, meas_req, frame_done, busy, host_oe;
  wire line = ~sda_oe & ~host_oe;
  int n_errors = 0;
  int comparisons = 0;
  int n_done = 0;
  int n_req = 0;
  always @(posedge sys_clk) begin
    if (frame_done === 1'b1) n_done++;
    if (meas_req === 1'b1) n_req++;
  end
  swsr_sensor #(.START_CYC(40)) u_dut (.sys_clk, .rstn, .clk_en, .sda_in(line), .sda_out,
    .sda_oe, .samp_valid, .samp_data, .samp_ready, .meas_req, .frame_done, .busy);
  swsr_host_model u_host (.sys_clk, .line, .host_oe);
  initial forever #50 sys_clk = ~sys_clk;
  task automatic check(input string name, input logic [39:0] exp, input logic [39:0] got);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", name, exp, got);
    end
  endtask
  task automatic stop_test();
    if (n_errors == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Wire image: sign and magnitude temperature, then byte sum
  function automatic logic [39:0] frame(input logic [31:0] s);
    logic [15:0] t;
    t = s[15] ? (16'h8000 | (~s[15:0] + 16'h0001)) : s[15:0];
    return {s[31:16], t, s[31:24] + s[23:16] + t[15:8] + t[7:0]};
  endfunction
  task automatic t_short();
    u_host.pulse(20);
    repeat (400) @(posedge sys_clk);
    check("busy", 40'h0, {39'h0, busy});
  endtask
  // A start pulse while the clock enable is low must leave the sensor asleep
  task automatic t_freeze();
    clk_en <= 1'b0;
    u_host.pulse(60);
    repeat (10) @(posedge sys_clk);
    check("frozen", 40'h0, {39'h0, busy});
    clk_en <= 1'b1;
    @(posedge sys_clk);
  endtask
  task automatic t_queue();
    logic [31:0] s[3] = '{SA, 32'h03e7_010d, 32'h0001_0001};
    samp_valid <= 1'b1;
    foreach (s[i]) begin
      samp_data <= s[i];
      @(posedge sys_clk);
    end
    samp_valid <= 1'b0;
    check("ready", 40'h0, {39'h0, samp_ready});
  endtask
  task automatic t_reads();
    logic [39:0] got;
    logic ok;
    u_host.read(60, got, ok);
    check("ok1", 40'h1, {39'h0, ok});
    check("frame1", frame(32'h0), got);
    repeat (3) @(posedge sys_clk);
    check("ready", 40'h1, {39'h0, samp_ready});
    check("done1", 40'h1, 40'(n_done));
    check("req1", 40'h1, 40'(n_req));
    check("sda_out", 40'h0, {39'h0, sda_out});
    u_host.read(60, got, ok);
    check("ok2", 40'h1, {39'h0, ok});
    check("frame2", frame(SA), got);
    repeat (3) @(posedge sys_clk);
    check("done2", 40'h2, 40'(n_done));
    check("idle", 40'h0, {39'h0, busy});
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_short();
    t_freeze();
    t_queue();
    t_reads();
    stop_test();
  end
  // Two frames take about 75000 cycles
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_errors++;
    stop_test();
  end
endmodule
